// File: core/pac_handler.sv
// parameter access command handler: frame decode, parameter tables
// assumes byte strobes synchronous to clk and a nvm with req/done
// handshake; nvm read data valid with nvm_done
`timescale 1ns/100ps
module pac_handler (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// frame bytes in
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	// reply out
	output logic reply_valid_ff,
	output pac_pkg::pac_reply_t reply_ff,
	output logic [31:0] accu_ff,
	output logic ready_ff,
	// non-volatile memory
	output logic nvm_req_ff,
	output pac_pkg::pac_nvm_req_t nvm_cmd_ff,
	input wire logic nvm_done,
	input wire logic [31:0] nvm_rdata
);
	typedef enum {PAC_BOOT, PAC_BOOTW, PAC_IDLE, PAC_EXEC, PAC_NVMW}
		pac_state_t;

	pac_state_t state_ff, nxt_state;
	logic [3:0] idx_ff, nxt_idx;
	logic [7:0] sum_ff, nxt_sum;
	pac_pkg::pac_cmd_t cmd_ff, nxt_cmd;
	logic sum_ok_ff, nxt_sum_ok;
	logic [7:0] boot_ff, nxt_boot;
	logic nxt_reply_valid;
	pac_pkg::pac_reply_t nxt_reply;
	logic [31:0] nxt_accu;
	logic nxt_ready;
	logic nxt_nvm_req;
	pac_pkg::pac_nvm_req_t nxt_nvm_cmd;

	logic [31:0] axis_mem [pac_pkg::NPAR];
	logic [31:0] glob_mem [pac_pkg::NBANK][pac_pkg::NPAR];
	logic axis_we;
	logic [7:0] axis_wa;
	logic [31:0] axis_wd;
	logic glob_we;
	logic [1:0] glob_wb;
	logic [31:0] glob_wd;
	logic [1:0] bidx;
	logic bank_ok;

	// ----------------------------------------------------------------
	// bank decode
	// ----------------------------------------------------------------
	always_comb begin
		bidx = pac_pkg::BIDX_SETTINGS;
		bank_ok = 1'b1;
		case (cmd_ff.bank)
			pac_pkg::BANK_SETTINGS: bidx = pac_pkg::BIDX_SETTINGS;
			pac_pkg::BANK_USER: bidx = pac_pkg::BIDX_USER;
			pac_pkg::BANK_IRQ: bidx = pac_pkg::BIDX_IRQ;
			default: bank_ok = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		nxt_sum = sum_ff;
		nxt_cmd = cmd_ff;
		nxt_sum_ok = sum_ok_ff;
		nxt_boot = boot_ff;
		nxt_reply_valid = 1'b0;
		nxt_reply = reply_ff;
		nxt_accu = accu_ff;
		nxt_ready = ready_ff;
		nxt_nvm_req = 1'b0;
		nxt_nvm_cmd = nvm_cmd_ff;
		axis_we = 1'b0;
		axis_wa = cmd_ff.typ;
		axis_wd = nvm_rdata;
		glob_we = 1'b0;
		glob_wb = bidx;
		glob_wd = cmd_ff.value;
		case (state_ff)
			PAC_BOOT: begin
				nxt_nvm_req = 1'b1;
				nxt_nvm_cmd = '{1'b0, 1'b1, 1'b0,
					pac_pkg::BIDX_SETTINGS, boot_ff, pac_pkg::WORD_ZERO};
				nxt_state = PAC_BOOTW;
			end
			PAC_BOOTW: begin
				if (nvm_done) begin
					axis_we = 1'b1;
					axis_wa = boot_ff;
					if (boot_ff == pac_pkg::PAR_LAST) begin
						nxt_state = PAC_IDLE;
						nxt_ready = 1'b1;
					end else begin
						nxt_boot = boot_ff + 8'h01;
						nxt_state = PAC_BOOT;
					end
				end
			end
			PAC_IDLE: begin
				if (rx_valid) begin
					nxt_idx = idx_ff + 4'h1;
					nxt_sum = sum_ff + rx_byte;
					case (idx_ff)
						4'h0: nxt_cmd.addr = rx_byte;
						4'h1: nxt_cmd.ins = rx_byte;
						4'h2: nxt_cmd.typ = rx_byte;
						4'h3: nxt_cmd.bank = rx_byte;
						4'h4: nxt_cmd.value[31:24] = rx_byte;
						4'h5: nxt_cmd.value[23:16] = rx_byte;
						4'h6: nxt_cmd.value[15:8] = rx_byte;
						4'h7: nxt_cmd.value[7:0] = rx_byte;
						default: begin
						end
					endcase
					if (idx_ff == pac_pkg::FRAME_LAST) begin
						nxt_sum_ok = (rx_byte == sum_ff);
						nxt_idx = pac_pkg::IDX_ZERO;
						nxt_sum = pac_pkg::BYTE_ZERO;
						nxt_state = PAC_EXEC;
						nxt_ready = 1'b0;
					end
				end
			end
			PAC_EXEC: begin
				nxt_reply = '{cmd_ff.addr, pac_pkg::ST_OK, cmd_ff.ins,
					pac_pkg::WORD_ZERO};
				nxt_state = PAC_IDLE;
				nxt_ready = 1'b1;
				nxt_reply_valid = 1'b1;
				if (!sum_ok_ff) begin
					nxt_reply.status = pac_pkg::ST_BAD_SUM;
				end else begin
					case (cmd_ff.ins)
						pac_pkg::INS_READ_AXIS: begin
							if (cmd_ff.bank != pac_pkg::BANK_SETTINGS) begin
								nxt_reply.status = pac_pkg::ST_BAD_VALUE;
							end else begin
								nxt_accu = axis_mem[cmd_ff.typ];
								nxt_reply.value = axis_mem[cmd_ff.typ];
							end
						end
						pac_pkg::INS_STORE_AXIS,
						pac_pkg::INS_RESTORE_AXIS: begin
							nxt_nvm_req = 1'b1;
							nxt_nvm_cmd = '{cmd_ff.ins == pac_pkg::INS_STORE_AXIS,
								cmd_ff.ins == pac_pkg::INS_RESTORE_AXIS, 1'b0,
								pac_pkg::BIDX_SETTINGS, cmd_ff.typ,
								axis_mem[cmd_ff.typ]};
							nxt_state = PAC_NVMW;
							nxt_ready = 1'b0;
							nxt_reply_valid = 1'b0;
						end
						pac_pkg::INS_WRITE_GLOBAL: begin
							if (!bank_ok) begin
								nxt_reply.status = pac_pkg::ST_BAD_TYPE;
							end else begin
								glob_we = 1'b1;
								if (bidx == pac_pkg::BIDX_SETTINGS) begin
									nxt_nvm_req = 1'b1;
									nxt_nvm_cmd = '{1'b1, 1'b0, 1'b1, bidx,
										cmd_ff.typ, cmd_ff.value};
									nxt_state = PAC_NVMW;
									nxt_ready = 1'b0;
									nxt_reply_valid = 1'b0;
								end
							end
						end
						pac_pkg::INS_READ_GLOBAL: begin
							if (!bank_ok) begin
								nxt_reply.status = pac_pkg::ST_BAD_TYPE;
							end else begin
								nxt_accu = glob_mem[bidx][cmd_ff.typ];
								nxt_reply.value = glob_mem[bidx][cmd_ff.typ];
							end
						end
						pac_pkg::INS_STORE_GLOBAL: begin
							if (!bank_ok) begin
								nxt_reply.status = pac_pkg::ST_BAD_TYPE;
							end else begin
								nxt_nvm_req = 1'b1;
								nxt_nvm_cmd = '{1'b1, 1'b0, 1'b1, bidx,
									cmd_ff.typ, glob_mem[bidx][cmd_ff.typ]};
								nxt_state = PAC_NVMW;
								nxt_ready = 1'b0;
								nxt_reply_valid = 1'b0;
							end
						end
						default: nxt_reply.status = pac_pkg::ST_BAD_CMD;
					endcase
				end
			end
			PAC_NVMW: begin
				if (nvm_done) begin
					axis_we = nvm_cmd_ff.rd;
					axis_wa = nvm_cmd_ff.idx;
					nxt_reply_valid = 1'b1;
					nxt_ready = 1'b1;
					nxt_state = PAC_IDLE;
				end
			end
			default: nxt_state = PAC_BOOT;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= PAC_BOOT;
			idx_ff <= pac_pkg::IDX_ZERO;
			sum_ff <= pac_pkg::BYTE_ZERO;
			cmd_ff <= '0;
			sum_ok_ff <= 1'b0;
			boot_ff <= pac_pkg::BYTE_ZERO;
			reply_valid_ff <= 1'b0;
			reply_ff <= '0;
			accu_ff <= pac_pkg::WORD_ZERO;
			ready_ff <= 1'b0;
			nvm_req_ff <= 1'b0;
			nvm_cmd_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			sum_ff <= nxt_sum;
			cmd_ff <= nxt_cmd;
			sum_ok_ff <= nxt_sum_ok;
			boot_ff <= nxt_boot;
			reply_valid_ff <= nxt_reply_valid;
			reply_ff <= nxt_reply;
			accu_ff <= nxt_accu;
			ready_ff <= nxt_ready;
			nvm_req_ff <= nxt_nvm_req;
			nvm_cmd_ff <= nxt_nvm_cmd;
		end
	end

	// ----------------------------------------------------------------
	// parameter tables
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (axis_we) begin
			axis_mem[axis_wa] <= axis_wd;
		end
		if (glob_we) begin
			glob_mem[glob_wb][cmd_ff.typ] <= glob_wd;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	axis_read_ok_a: assert property (@(posedge clk) disable iff (sys_rst)
		state_ff == PAC_EXEC && sum_ok_ff &&
		cmd_ff.ins == pac_pkg::INS_READ_AXIS &&
		cmd_ff.bank == pac_pkg::BANK_SETTINGS
		|=> reply_valid_ff && reply_ff.status == pac_pkg::ST_OK &&
		reply_ff.value == accu_ff)
		else $error("axis read reply wrong");
	bad_sum_a: assert property (@(posedge clk) disable iff (sys_rst)
		state_ff == PAC_EXEC && !sum_ok_ff
		|=> reply_valid_ff && reply_ff.status == pac_pkg::ST_BAD_SUM &&
		!nvm_req_ff)
		else $error("bad checksum not refused");
	store_axis_a: assert property (@(posedge clk) disable iff (sys_rst)
		state_ff == PAC_EXEC && sum_ok_ff &&
		cmd_ff.ins == pac_pkg::INS_STORE_AXIS
		|=> nvm_req_ff && nvm_cmd_ff.wr && !nvm_cmd_ff.glob &&
		nvm_cmd_ff.idx == $past(cmd_ff.typ))
		else $error("axis store not issued");
	restore_axis_a: assert property (@(posedge clk) disable iff (sys_rst)
		state_ff == PAC_EXEC && sum_ok_ff &&
		cmd_ff.ins == pac_pkg::INS_RESTORE_AXIS
		|=> nvm_req_ff && nvm_cmd_ff.rd && !reply_valid_ff)
		else $error("axis restore not issued");
	boot_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		(state_ff == PAC_BOOT || state_ff == PAC_BOOTW) |-> !ready_ff)
		else $error("ready during boot reload");
	settings_nvm_a: assert property (@(posedge clk) disable iff (sys_rst)
		state_ff == PAC_EXEC && sum_ok_ff && bank_ok &&
		cmd_ff.ins == pac_pkg::INS_WRITE_GLOBAL &&
		cmd_ff.bank == pac_pkg::BANK_SETTINGS
		|=> nvm_req_ff && nvm_cmd_ff.wr && nvm_cmd_ff.glob &&
		nvm_cmd_ff.data == $past(cmd_ff.value))
		else $error("settings write not copied");
	bad_bank_a: assert property (@(posedge clk) disable iff (sys_rst)
		state_ff == PAC_EXEC && sum_ok_ff && !bank_ok &&
		cmd_ff.ins == pac_pkg::INS_READ_GLOBAL
		|=> reply_ff.status == pac_pkg::ST_BAD_TYPE)
		else $error("bad bank accepted");
	store_glob_a: assert property (@(posedge clk) disable iff (sys_rst)
		state_ff == PAC_EXEC && sum_ok_ff && bank_ok &&
		cmd_ff.ins == pac_pkg::INS_STORE_GLOBAL
		|=> nvm_req_ff && nvm_cmd_ff.glob && nvm_cmd_ff.wr)
		else $error("global store not issued");
endmodule

// File: core/pac_pkg.sv
// package for the parameter access command handler
// assumes one 100 MHz clock domain and byte-wide frame input
package pac_pkg;
	localparam int ADDR_W = 8;
	localparam int NPAR = 256;
	localparam int NBANK = 3;

	localparam logic [7:0] INS_READ_AXIS = 8'h06;
	localparam logic [7:0] INS_STORE_AXIS = 8'h07;
	localparam logic [7:0] INS_RESTORE_AXIS = 8'h08;
	localparam logic [7:0] INS_WRITE_GLOBAL = 8'h09;
	localparam logic [7:0] INS_READ_GLOBAL = 8'h0a;
	localparam logic [7:0] INS_STORE_GLOBAL = 8'h0b;

	localparam logic [7:0] BANK_SETTINGS = 8'h00;
	localparam logic [7:0] BANK_USER = 8'h02;
	localparam logic [7:0] BANK_IRQ = 8'h03;
	localparam logic [1:0] BIDX_SETTINGS = 2'h0;
	localparam logic [1:0] BIDX_USER = 2'h1;
	localparam logic [1:0] BIDX_IRQ = 2'h2;

	localparam logic [7:0] ST_OK = 8'h64;
	localparam logic [7:0] ST_BAD_SUM = 8'h01;
	localparam logic [7:0] ST_BAD_CMD = 8'h02;
	localparam logic [7:0] ST_BAD_TYPE = 8'h03;
	localparam logic [7:0] ST_BAD_VALUE = 8'h04;

	localparam logic [3:0] FRAME_LAST = 4'h8;
	localparam logic [3:0] IDX_ZERO = 4'h0;
	localparam logic [7:0] PAR_LAST = 8'hff;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] ins;
		logic [7:0] typ;
		logic [7:0] bank;
		logic [31:0] value;
	} pac_cmd_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] status;
		logic [7:0] ins;
		logic [31:0] value;
	} pac_reply_t;

	// non-volatile memory request
	typedef struct packed {
		logic wr;
		logic rd;
		logic glob;
		logic [1:0] bank;
		logic [7:0] idx;
		logic [31:0] data;
	} pac_nvm_req_t;
endpackage

// File: sim/pac_nvm_model.sv
// nvm behavioural model facing the command handler
// assumes one request in flight; answer comes lat cycles after it
`timescale 1ns/100ps
module pac_nvm_model (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// request side
	input wire logic nvm_req_ff,
	input wire pac_pkg::pac_nvm_req_t nvm_cmd_ff,
	input wire logic [7:0] lat,
	// answer side
	output logic nvm_done,
	output logic [31:0] nvm_rdata
);
	logic [31:0] ax_mem [256];
	logic [31:0] gl_mem [3][256];
	pac_pkg::pac_nvm_req_t cmd;
	logic [7:0] cnt;
	initial begin
		for (int i = 0; i < 256; i++) begin
			ax_mem[i] = {8'ha5, 16'h0000, i[7:0]};
			for (int b = 0; b < 3; b++) gl_mem[b][i] = 32'h0000_0000;
		end
	end
	// read data is junk outside the done cycle
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 8'h00;
			nvm_done <= 1'b0;
			nvm_rdata <= 32'h0000_0000;
		end else begin
			nvm_done <= 1'b0;
			nvm_rdata <= ~nvm_rdata;
			if (nvm_req_ff) begin
				cmd <= nvm_cmd_ff;
				cnt <= lat;
			end else if (cnt == 8'h01) begin
				cnt <= 8'h00;
				nvm_done <= 1'b1;
				if (cmd.rd && cmd.glob) nvm_rdata <= gl_mem[cmd.bank][cmd.idx];
				else if (cmd.rd) nvm_rdata <= ax_mem[cmd.idx];
				if (cmd.wr && cmd.glob) gl_mem[cmd.bank][cmd.idx] <= cmd.data;
				else if (cmd.wr) ax_mem[cmd.idx] <= cmd.data;
			end else if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule

// File: sim/tb_top.sv
// self-checking bench for the parameter access command handler
// assumes pac_nvm_model answers nvm requests after lat cycles
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
	$display("ERROR %s exp %h got %h", n, e, g); n_errors++; end end
module tb_top;
	logic clk, sys_rst, rx_valid, reply_valid_ff, ready_ff, nvm_req_ff;
	logic nvm_done;
	logic [7:0] rx_byte, lat;
	logic [31:0] accu_ff, nvm_rdata;
	pac_pkg::pac_reply_t reply_ff, rep;
	pac_pkg::pac_nvm_req_t nvm_cmd_ff;
	int n_errors = 0;
	int checked = 0;
	pac_handler pac_handler_i (.clk(clk), .sys_rst(sys_rst),
		.rx_valid(rx_valid), .rx_byte(rx_byte),
		.reply_valid_ff(reply_valid_ff), .reply_ff(reply_ff),
		.accu_ff(accu_ff), .ready_ff(ready_ff), .nvm_req_ff(nvm_req_ff),
		.nvm_cmd_ff(nvm_cmd_ff), .nvm_done(nvm_done),
		.nvm_rdata(nvm_rdata));
	pac_nvm_model pac_nvm_model_i (.clk(clk), .sys_rst(sys_rst),
		.nvm_req_ff(nvm_req_ff), .nvm_cmd_ff(nvm_cmd_ff), .lat(lat),
		.nvm_done(nvm_done), .nvm_rdata(nvm_rdata));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic test_done;
		if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// one whole frame, then wait for the reply
	task automatic frame(input logic [7:0] ins, typ, bnk,
		input logic [31:0] v, input logic [7:0] bad, st);
		logic [7:0] b [9];
		int i;
		b = '{8'h01, ins, typ, bnk, v[31:24], v[23:16], v[15:8], v[7:0],
			8'h00};
		for (i = 0; i < 8; i++) b[8] = b[8] + b[i];
		b[8] = b[8] ^ bad;
		for (i = 0; i < 9; i++) begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_byte <= b[i];
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		for (i = 0; i < 400 && reply_valid_ff !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 400) begin
			n_errors++;
			test_done();
		end else begin
			rep = reply_ff;
			`CHK("status", st, rep.status)
			`CHK("addr echo", 8'h01, rep.addr)
			`CHK("ins echo", ins, rep.ins)
			`CHK("ready", 1'b1, ready_ff)
		end
	endtask
	task automatic t_axis_read;
		frame(pac_pkg::INS_READ_AXIS, 8'h05, 8'h00, 32'h0, 8'h00,
			pac_pkg::ST_OK);
		`CHK("axis value", 32'ha500_0005, rep.value)
		`CHK("accu axis", 32'ha500_0005, accu_ff)
		frame(pac_pkg::INS_READ_AXIS, 8'h05, 8'h01, 32'h0, 8'h00,
			pac_pkg::ST_BAD_VALUE);
	endtask
	task automatic t_axis_nvm;
		lat <= 8'h06;
		pac_nvm_model_i.ax_mem[6] = 32'hdead_beef;
		frame(pac_pkg::INS_RESTORE_AXIS, 8'h06, 8'h00, 32'h0, 8'h00,
			pac_pkg::ST_OK);
		frame(pac_pkg::INS_READ_AXIS, 8'h06, 8'h00, 32'h0, 8'h00,
			pac_pkg::ST_OK);
		`CHK("restored", 32'hdead_beef, rep.value)
		pac_nvm_model_i.ax_mem[6] = 32'h0000_0000;
		frame(pac_pkg::INS_STORE_AXIS, 8'h06, 8'h00, 32'h1234_5678, 8'h00,
			pac_pkg::ST_OK);
		`CHK("stored", 32'hdead_beef, pac_nvm_model_i.ax_mem[6])
		lat <= 8'h01;
	endtask
	task automatic t_global;
		logic [7:0] bk [3];
		logic [31:0] v;
		bk = '{8'h00, 8'h02, 8'h03};
		for (int k = 0; k < 3; k++) begin
			frame(pac_pkg::INS_WRITE_GLOBAL, 8'h2a, bk[k], {24'h876543, bk[k]},
				8'h00, pac_pkg::ST_OK);
		end
		for (int k = 0; k < 3; k++) begin
			v = {24'h876543, bk[k]};
			frame(pac_pkg::INS_READ_GLOBAL, 8'h2a, bk[k], 32'h0, 8'h00,
				pac_pkg::ST_OK);
			`CHK("global", v, rep.value)
			`CHK("accu global", v, accu_ff)
		end
		`CHK("bank0 auto", 32'h8765_4300, pac_nvm_model_i.gl_mem[0][42])
		`CHK("bank2 kept", 32'h0, pac_nvm_model_i.gl_mem[1][42])
		frame(pac_pkg::INS_WRITE_GLOBAL, 8'h2a, 8'h01, 32'h5, 8'h00,
			pac_pkg::ST_BAD_TYPE);
	endtask
	task automatic t_store_global;
		frame(pac_pkg::INS_STORE_GLOBAL, 8'h2a, 8'h02, 32'hffff_ffff, 8'h00,
			pac_pkg::ST_OK);
		`CHK("store reply", 32'h0, rep.value)
		`CHK("bank2 nvm", 32'h8765_4302, pac_nvm_model_i.gl_mem[1][42])
		frame(pac_pkg::INS_STORE_GLOBAL, 8'h2a, 8'h01, 32'h0, 8'h00,
			pac_pkg::ST_BAD_TYPE);
	endtask
	task automatic t_bad_frame;
		frame(pac_pkg::INS_WRITE_GLOBAL, 8'h2a, 8'h02, 32'h1111_1111, 8'h01,
			pac_pkg::ST_BAD_SUM);
		frame(pac_pkg::INS_READ_GLOBAL, 8'h2a, 8'h02, 32'h0, 8'h00,
			pac_pkg::ST_OK);
		`CHK("unchanged", 32'h8765_4302, rep.value)
		frame(pac_pkg::INS_READ_GLOBAL, 8'h2a, 8'h01, 32'h0, 8'h00,
			pac_pkg::ST_BAD_TYPE);
		frame(8'h05, 8'h00, 8'h00, 32'h0, 8'h00, pac_pkg::ST_BAD_CMD);
	endtask
	initial begin
		sys_rst = 1'b1;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		lat = 8'h01;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 5000 && ready_ff !== 1'b1; i++) @(posedge clk);
		if (ready_ff !== 1'b1) begin
			n_errors++;
		end else begin
			t_axis_read();
			t_axis_nvm();
			t_global();
			t_store_global();
			t_bad_frame();
		end
		test_done();
	end
endmodule
